// ### inc/rhpc_pkg.sv
/*
  Constants for the reset, halt and power control block: register map,
  field positions, reset values, state codes and timing counts.
  Assumes a 100 MHz system clock and a 32-bit Avalon-MM slave port.
*/
package rhpc_pkg;

  // Register byte addresses
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFS_SMR_EN = 5'h00;
  localparam logic [4:0] OFS_PWR_CLK = 5'h04;
  localparam logic [4:0] OFS_PWR_OFF = 5'h08;
  localparam logic [4:0] OFS_DBG_CTL = 5'h0c;
  localparam logic [4:0] OFS_STATUS = 5'h10;

  // Reset values
  localparam logic [7:0] SMR_EN_RST = 8'h00;
  localparam logic [7:0] PWR_CLK_RST = 8'h00;
  localparam logic [7:0] PWR_OFF_RST = 8'h00;

  // Debugger control field
  localparam int DBG_RST_BIT = 0;

  // Status fields: cause flags in the low bits, state code above
  localparam int CAUSE_W = 7;
  localparam int CAUSE_POR = 0;
  localparam int CAUSE_BOR = 1;
  localparam int CAUSE_WDT = 2;
  localparam int CAUSE_PIN = 3;
  localparam int CAUSE_DBG = 4;
  localparam int CAUSE_SMR_WDT = 5;
  localparam int CAUSE_SMR_GPIO = 6;
  localparam int STATE_LSB = 8;

  localparam int NPERIPH = 8;
  localparam int NGPIO = 8;

  // Timing
  localparam int CLK_MHZ = 100;
  localparam int RST_HOLD_NS = 660;
  localparam int SMR_HOLD_NS = 200;
  localparam int XTAL_START_US = 50;
  localparam logic [15:0] RST_HOLD_CYC = 16'((RST_HOLD_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] SMR_HOLD_CYC = 16'((SMR_HOLD_NS * CLK_MHZ + 999) / 1000);
  localparam int XTAL_START_CYC_DEF = XTAL_START_US * CLK_MHZ;

  typedef enum logic [4:0] {
    ST_RESET = 5'h01,
    ST_RUN = 5'h02,
    ST_HALT = 5'h04,
    ST_STOP = 5'h08,
    ST_SMR = 5'h10
  } rhpc_state_e;

endpackage

// ### logic/rhpc_sync.sv
/*
  Two-flop synchroniser, one per bit, with a per-bit reset value.
  Assumes the destination clock is the system clock.
*/
`timescale 1ns/1ns
module rhpc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Data
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  for (genvar b = 0; b < WIDTH; b++)
  begin : g_bit
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
      begin
        meta_q[b] <= RST_VAL[b];
        q_o[b] <= RST_VAL[b];
      end
      else
      begin
        meta_q[b] <= d_i[b];
        q_o[b] <= meta_q[b];
      end
    end
  end

endmodule

// ### logic/rhpc_top.sv
/*
  Reset, stop-recovery, halt and peripheral power control for a small
  8-bit controller, with an Avalon-MM register slave.
  Assumes CPU-side strobes are synchronous to clk_i; detector, watchdog,
  reset pin and GPIO levels may be asynchronous and are synchronised here.
*/
// Chosen here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
module rhpc_top #(
  parameter int XTAL_START_CYC = rhpc_pkg::XTAL_START_CYC_DEF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Avalon-MM slave
  input wire logic [rhpc_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Reset sources
  input wire logic por_i,
  input wire logic supply_brownout_reset_i,
  input wire logic watchdog_timer_timeout_i,
  input wire logic watchdog_reset_select_option_i,
  input wire logic ext_reset_n_i,
  input wire logic reset_pin_alt_en_i,
  input wire logic xtal_en_option_i,
  // Stop recovery sources
  input wire logic [rhpc_pkg::NGPIO-1:0] gpio_i,
  // CPU core
  input wire logic halt_instr_i,
  input wire logic stop_instr_i,
  input wire logic irq_i,
  // Reset and mode outputs
  output logic sys_reset_n_o,
  output logic stop_recovery_o,
  output logic cpu_run_o,
  output logic halt_mode_o,
  output logic stop_mode_o,
  output logic osc_en_o,
  output logic sys_clk_en_o,
  output logic wdt_osc_en_o,
  // Peripheral power control
  output logic [rhpc_pkg::NPERIPH-1:0] periph_clk_dis_o,
  output logic [rhpc_pkg::NPERIPH-1:0] periph_pwr_dis_o
);

  import rhpc_pkg::*;

  typedef struct packed {
    rhpc_state_e state;
    logic [15:0] cnt;
    logic arm;
    logic bus_wait;
    logic [31:0] rdata;
    logic [NGPIO-1:0] smr_en;
    logic [NPERIPH-1:0] pwr_clk;
    logic [NPERIPH-1:0] pwr_off;
    logic dbg_rst;
    logic [CAUSE_W-1:0] cause;
    logic [NGPIO-1:0] gpio_prev;
    logic sys_rst_n;
    logic smr_act;
    logic cpu_run;
    logic halt;
    logic stop;
    logic osc_en;
  } rhpc_regs_s;

  rhpc_regs_s st_q;
  rhpc_regs_s st_d;

  localparam rhpc_regs_s ST_RST_VAL = '{
    state: ST_RESET,
    cnt: 16'h0000,
    arm: 1'b1,
    bus_wait: 1'b1,
    rdata: 32'h0000_0000,
    smr_en: SMR_EN_RST,
    pwr_clk: PWR_CLK_RST,
    pwr_off: PWR_OFF_RST,
    dbg_rst: 1'b0,
    cause: 7'h00,
    gpio_prev: 8'h00,
    sys_rst_n: 1'b0,
    smr_act: 1'b0,
    cpu_run: 1'b0,
    halt: 1'b0,
    stop: 1'b0,
    osc_en: 1'b1
  };

  // Synchronised asynchronous sources
  logic [11:0] async_raw;
  logic [11:0] async_s;
  logic por_s;
  logic bor_s;
  logic wdt_s;
  logic pin_n_s;
  logic [NGPIO-1:0] gpio_s;

  assign async_raw = {gpio_i, ext_reset_n_i, watchdog_timer_timeout_i,
                      supply_brownout_reset_i, por_i};

  // Pin idles high so it must not look asserted right after reset
  rhpc_sync #(
    .WIDTH(12),
    .RST_VAL(12'h008)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(async_raw),
    .q_o(async_s)
  );

  assign por_s = async_s[0];
  assign bor_s = async_s[1];
  assign wdt_s = async_s[2];
  assign pin_n_s = async_s[3];
  assign gpio_s = async_s[11:4];

  // Decoded requests
  logic wdt_rst;
  logic pin_rst;
  logic full_req;
  logic gpio_evt;
  logic [15:0] hold_len;
  logic bus_req;
  logic bus_take;
  logic bus_done;
  logic [CAUSE_W-1:0] cause_set;

  always_comb
  begin
    // Watchdog in STOP recovers instead of resetting
    wdt_rst = wdt_s & watchdog_reset_select_option_i & ~st_q.stop;
    pin_rst = ~pin_n_s & reset_pin_alt_en_i;
    full_req = por_s | bor_s | wdt_rst | pin_rst | st_q.dbg_rst;
    gpio_evt = |((gpio_s ^ st_q.gpio_prev) & st_q.smr_en);
    hold_len = RST_HOLD_CYC;
    if (xtal_en_option_i)
    begin
      hold_len = RST_HOLD_CYC + 16'(XTAL_START_CYC);
    end
    cause_set = '0;
    cause_set[CAUSE_POR] = por_s;
    cause_set[CAUSE_BOR] = bor_s;
    cause_set[CAUSE_WDT] = wdt_rst;
    cause_set[CAUSE_PIN] = pin_rst;
    cause_set[CAUSE_DBG] = st_q.dbg_rst;
    if (st_q.state == ST_STOP)
    begin
      cause_set[CAUSE_SMR_WDT] = wdt_s;
      cause_set[CAUSE_SMR_GPIO] = gpio_evt;
    end
    bus_req = avs_read_i | avs_write_i;
    bus_take = bus_req & st_q.bus_wait;
    bus_done = bus_req & ~st_q.bus_wait;
  end

  always_comb
  begin
    st_d = st_q;
    st_d.gpio_prev = gpio_s;

    case (st_q.state)
      ST_RESET:
      begin
        if (st_q.arm)
        begin
          st_d.cnt = hold_len;
          st_d.arm = 1'b0;
        end
        else if (st_q.cnt == 16'h0000)
        begin
          st_d.state = ST_RUN;
        end
        else
        begin
          st_d.cnt = st_q.cnt - 16'h0001;
        end
      end
      ST_RUN:
      begin
        // STOP wins if both strobes come together
        if (stop_instr_i)
        begin
          st_d.state = ST_STOP;
        end
        else if (halt_instr_i)
        begin
          st_d.state = ST_HALT;
        end
      end
      ST_HALT:
      begin
        // Reset-kind exits are taken by full_req below
        if (irq_i | wdt_s)
        begin
          st_d.state = ST_RUN;
        end
      end
      ST_STOP:
      begin
        if (wdt_s | gpio_evt)
        begin
          st_d.state = ST_SMR;
          st_d.cnt = SMR_HOLD_CYC;
        end
      end
      ST_SMR:
      begin
        // Register contents survive recovery, unlike a full reset
        if (st_q.cnt == 16'h0000)
        begin
          st_d.state = ST_RUN;
        end
        else
        begin
          st_d.cnt = st_q.cnt - 16'h0001;
        end
      end
      default:
      begin
        st_d.state = ST_RESET;
        st_d.arm = 1'b1;
      end
    endcase

    // Full reset overrides every mode and restarts the interval
    if (full_req)
    begin
      st_d.state = ST_RESET;
      st_d.cnt = hold_len;
      st_d.arm = 1'b0;
      st_d.dbg_rst = 1'b0;
    end

    // Bus: take at first edge, complete at the edge waitrequest is low
    st_d.bus_wait = ~bus_take;
    if (bus_take & avs_read_i)
    begin
      st_d.rdata = 32'h0000_0000;
      case (avs_address_i)
        OFS_SMR_EN:
        begin
          st_d.rdata[NGPIO-1:0] = st_q.smr_en;
        end
        OFS_PWR_CLK:
        begin
          st_d.rdata[NPERIPH-1:0] = st_q.pwr_clk;
        end
        OFS_PWR_OFF:
        begin
          st_d.rdata[NPERIPH-1:0] = st_q.pwr_off;
        end
        OFS_DBG_CTL:
        begin
          st_d.rdata[DBG_RST_BIT] = st_q.dbg_rst;
        end
        OFS_STATUS:
        begin
          st_d.rdata[CAUSE_W-1:0] = st_q.cause;
          st_d.rdata[STATE_LSB+4:STATE_LSB] = st_q.state;
        end
        default:
        begin
          st_d.rdata = 32'h0000_0000;
        end
      endcase
    end

    if (bus_done & avs_write_i & avs_byteenable_i[0])
    begin
      case (avs_address_i)
        OFS_SMR_EN:
        begin
          st_d.smr_en = avs_writedata_i[NGPIO-1:0];
        end
        OFS_PWR_CLK:
        begin
          st_d.pwr_clk = avs_writedata_i[NPERIPH-1:0];
        end
        OFS_PWR_OFF:
        begin
          st_d.pwr_off = avs_writedata_i[NPERIPH-1:0];
        end
        OFS_DBG_CTL:
        begin
          if (avs_writedata_i[DBG_RST_BIT])
          begin
            st_d.dbg_rst = 1'b1;
          end
        end
        OFS_STATUS:
        begin
          st_d.cause = st_q.cause & ~avs_writedata_i[CAUSE_W-1:0];
        end
        default:
        begin
          st_d.cause = st_d.cause;
        end
      endcase
    end

    // A new cause in the clear cycle is kept
    st_d.cause = st_d.cause | cause_set;

    // System reset returns control registers to defaults
    if (full_req | (st_q.state == ST_RESET))
    begin
      st_d.smr_en = SMR_EN_RST;
      st_d.pwr_clk = PWR_CLK_RST;
      st_d.pwr_off = PWR_OFF_RST;
    end

    // Registered outputs follow the next state
    st_d.sys_rst_n = (st_d.state != ST_RESET);
    st_d.smr_act = (st_d.state == ST_SMR);
    st_d.cpu_run = (st_d.state == ST_RUN);
    st_d.halt = (st_d.state == ST_HALT);
    st_d.stop = (st_d.state == ST_STOP);
    // Only STOP parks the oscillator; HALT keeps it and the clock
    st_d.osc_en = (st_d.state != ST_STOP);
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_q <= ST_RST_VAL;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign avs_readdata_o = st_q.rdata;
  assign avs_waitrequest_o = st_q.bus_wait;
  assign sys_reset_n_o = st_q.sys_rst_n;
  assign stop_recovery_o = st_q.smr_act;
  assign cpu_run_o = st_q.cpu_run;
  assign halt_mode_o = st_q.halt;
  assign stop_mode_o = st_q.stop;
  assign osc_en_o = st_q.osc_en;
  assign sys_clk_en_o = st_q.osc_en;
  // Watchdog RC and peripherals are not gated by HALT
  assign wdt_osc_en_o = 1'b1;
  assign periph_clk_dis_o = st_q.pwr_clk;
  assign periph_pwr_dis_o = st_q.pwr_off;

endmodule

// ### sim/rhpc_checker.sv
/* Assertions on the reset, halt and stop ports of rhpc_top.
   Assumes one clock domain; bound from the bench top file. */
`timescale 1ns/1ns
module rhpc_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Sources and CPU strobes
  input wire logic por_i,
  input wire logic supply_brownout_reset_i,
  input wire logic watchdog_timer_timeout_i,
  input wire logic watchdog_reset_select_option_i,
  input wire logic ext_reset_n_i,
  input wire logic reset_pin_alt_en_i,
  input wire logic halt_instr_i,
  input wire logic stop_instr_i,
  input wire logic irq_i,
  // Mode outputs
  input wire logic sys_reset_n_o,
  input wire logic stop_recovery_o,
  input wire logic cpu_run_o,
  input wire logic halt_mode_o,
  input wire logic stop_mode_o,
  input wire logic osc_en_o,
  input wire logic sys_clk_en_o,
  input wire logic wdt_osc_en_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Two synchroniser stages plus one edge, one cycle of slack
  por_reset_a: assert property (por_i |-> ##[1:4] !sys_reset_n_o)
    else $error("power-on gave no reset");
  bor_reset_a: assert property (supply_brownout_reset_i |-> ##[1:4] !sys_reset_n_o)
    else $error("brown-out gave no reset");
  wdt_int_a: assert property (watchdog_timer_timeout_i && !watchdog_reset_select_option_i
    && cpu_run_o |=> sys_reset_n_o [*4])
    else $error("interrupt-kind watchdog reset the system");
  wdt_rst_a: assert property (watchdog_timer_timeout_i && watchdog_reset_select_option_i
    && (cpu_run_o || halt_mode_o) |-> ##[1:4] !sys_reset_n_o)
    else $error("reset-kind watchdog gave no reset");
  pin_reset_a: assert property (!ext_reset_n_i && reset_pin_alt_en_i |-> ##[1:4] !sys_reset_n_o)
    else $error("enabled reset pin gave no reset");
  halt_entry_a: assert property (halt_instr_i && !stop_instr_i && cpu_run_o
    |=> halt_mode_o && !cpu_run_o)
    else $error("halt instruction did not halt");
  halt_clk_a: assert property (halt_mode_o |-> osc_en_o && sys_clk_en_o && wdt_osc_en_o)
    else $error("clock or watchdog oscillator off in halt");
  halt_irq_a: assert property (halt_mode_o && irq_i |=> cpu_run_o)
    else $error("interrupt did not end halt");
  halt_wdt_a: assert property (halt_mode_o && watchdog_timer_timeout_i |-> ##[1:4] !halt_mode_o)
    else $error("watchdog did not end halt");
  stop_wdt_a: assert property (stop_mode_o && watchdog_timer_timeout_i
    |-> ##[1:4] stop_recovery_o)
    else $error("watchdog did not start stop recovery");
  smr_type_a: assert property ($rose(stop_recovery_o)
    |-> (sys_reset_n_o && stop_recovery_o) [*8])
    else $error("stop recovery short or took full reset");
  cover property (halt_mode_o ##1 cpu_run_o);
  cover property ($rose(stop_recovery_o));
  cover property ($fell(sys_reset_n_o));
endmodule

// ### sim/rhpc_cpu_model.sv
/* CPU core stand-in: turns bench requests into halt and stop
   instruction pulses and an interrupt level. Assumes the system clock. */
`timescale 1ns/1ns
module rhpc_cpu_model (
  // Clock, reset and core state
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cpu_run_i,
  // Request: 1 halt, 2 stop, 3 interrupt
  input wire logic [1:0] op_i,
  // To the block
  output logic halt_instr_o,
  output logic stop_instr_o,
  output logic irq_o
);
  // Only a running core executes; one pulse per instruction
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
      {halt_instr_o, stop_instr_o, irq_o} <= 3'h0;
    else
    begin
      halt_instr_o <= cpu_run_i && op_i == 2'h1 && !halt_instr_o;
      stop_instr_o <= cpu_run_i && op_i == 2'h2 && !stop_instr_o;
      irq_o <= op_i == 2'h3;
    end
endmodule

// ### sim/tb.sv
/* Self-checking bench for rhpc_top: Avalon tasks, CPU model, checker.
   Assumes the checker and CPU model are compiled first. */
`timescale 1ns/1ns
module tb;
  import rhpc_pkg::*;
  logic clk_i = 1'b0, rst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [4:0] avs_address_i = 5'h00;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic por_i = 1'b0, supply_brownout_reset_i = 1'b0, watchdog_timer_timeout_i = 1'b0;
  logic watchdog_reset_select_option_i = 1'b0, ext_reset_n_i = 1'b1;
  logic reset_pin_alt_en_i = 1'b0, xtal_en_option_i = 1'b0;
  logic [7:0] gpio_i = 8'h00, periph_clk_dis_o, periph_pwr_dis_o;
  logic [1:0] op = 2'h0;
  logic halt_instr_i, stop_instr_i, irq_i, avs_waitrequest_o, sys_reset_n_o, stop_recovery_o;
  logic cpu_run_o, halt_mode_o, stop_mode_o, osc_en_o, sys_clk_en_o, wdt_osc_en_o;
  int errors = 0, num_checks = 0, wn, n1;
  wire logic [4:0] mon = {stop_mode_o, stop_recovery_o, halt_mode_o, sys_reset_n_o, cpu_run_o};

  always #5 clk_i = ~clk_i;

  rhpc_top #(.XTAL_START_CYC(10)) u_rhpc_top (.clk_i, .rst_n_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .por_i, .supply_brownout_reset_i, .watchdog_timer_timeout_i,
    .watchdog_reset_select_option_i, .ext_reset_n_i, .reset_pin_alt_en_i, .xtal_en_option_i,
    .gpio_i, .halt_instr_i, .stop_instr_i, .irq_i, .sys_reset_n_o, .stop_recovery_o,
    .cpu_run_o, .halt_mode_o, .stop_mode_o, .osc_en_o, .sys_clk_en_o, .wdt_osc_en_o,
    .periph_clk_dis_o, .periph_pwr_dis_o);
  rhpc_cpu_model u_rhpc_cpu_model (.clk_i, .rst_n_i, .cpu_run_i(cpu_run_o), .op_i(op),
    .halt_instr_o(halt_instr_i), .stop_instr_o(stop_instr_i), .irq_o(irq_i));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic out_of_time;
    errors++;
    $display("[FAIL] %0t wait ran out", $time);
    give_verdict;
  endtask

  // Entered just after a rising edge; returns just after one
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !w;
    avs_write_i <= w;
    // Read straight after the edge: these are the values sampled at it
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50)
      out_of_time;
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Waits for one mode bit; wn gives the cycles spent
  task automatic wt(input int i, input logic v);
    wn = 0;
    do
    begin
      @(negedge clk_i);
      wn++;
    end
    while (mon[i] !== v && wn < 9000);
    if (wn >= 9000)
      out_of_time;
    @(posedge clk_i);
  endtask

  task automatic wdt_pulse;
    watchdog_timer_timeout_i <= 1'b1;
    @(posedge clk_i);
    watchdog_timer_timeout_i <= 1'b0;
  endtask

  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    wt(0, 1'b1);
    rdchk(OFS_SMR_EN, 32'(SMR_EN_RST));
    rdchk(OFS_PWR_CLK, 32'(PWR_CLK_RST));
    rdchk(5'h14, 32'h0);
    bus(1'b1, OFS_PWR_CLK, 32'ha5);
    chk(32'(periph_clk_dis_o), 32'ha5);
    bus(1'b1, OFS_PWR_OFF, 32'h3c);
    avs_byteenable_i <= 4'he;
    bus(1'b1, OFS_PWR_OFF, 32'hff);
    avs_byteenable_i <= 4'hf;
    chk(32'(periph_pwr_dis_o), 32'h3c);
    $display("register test done");
    op <= 2'h1;
    wt(2, 1'b1);
    chk(32'({cpu_run_o, osc_en_o, sys_clk_en_o, wdt_osc_en_o}), 32'h7);
    op <= 2'h3;
    wt(0, 1'b1);
    op <= 2'h1;
    wt(2, 1'b1);
    op <= 2'h0;
    wdt_pulse;
    wt(0, 1'b1);
    wdt_pulse;
    repeat (8) @(posedge clk_i);
    chk(32'(sys_reset_n_o), 32'h1);
    $display("halt test done");
    ext_reset_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(32'(sys_reset_n_o), 32'h1);
    reset_pin_alt_en_i <= 1'b1;
    wt(1, 1'b0);
    ext_reset_n_i <= 1'b1;
    reset_pin_alt_en_i <= 1'b0;
    wt(0, 1'b1);
    watchdog_reset_select_option_i <= 1'b1;
    wdt_pulse;
    wt(1, 1'b0);
    watchdog_reset_select_option_i <= 1'b0;
    wt(0, 1'b1);
    bus(1'b1, OFS_DBG_CTL, 32'h1);
    wt(1, 1'b0);
    wt(0, 1'b1);
    por_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    por_i <= 1'b0;
    wt(1, 1'b1);
    n1 = wn;
    chk(32'(n1 > 66), 32'h1);
    xtal_en_option_i <= 1'b1;
    supply_brownout_reset_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    supply_brownout_reset_i <= 1'b0;
    wt(1, 1'b1);
    chk(32'(wn - n1), 32'd10);
    xtal_en_option_i <= 1'b0;
    wt(0, 1'b1);
    $display("reset source test done");
    bus(1'b1, OFS_PWR_CLK, 32'h5a);
    bus(1'b1, OFS_SMR_EN, 32'h04);
    op <= 2'h2;
    wt(4, 1'b1);
    op <= 2'h0;
    gpio_i <= 8'h01;
    repeat (8) @(posedge clk_i);
    chk(32'(stop_mode_o), 32'h1);
    chk(32'({osc_en_o, sys_clk_en_o, wdt_osc_en_o}), 32'h1);
    gpio_i <= 8'h05;
    wt(3, 1'b1);
    chk(32'(sys_reset_n_o), 32'h1);
    wt(0, 1'b1);
    chk(32'(wn), 32'(SMR_HOLD_CYC) + 32'h1);
    rdchk(OFS_PWR_CLK, 32'h5a);
    op <= 2'h2;
    wt(4, 1'b1);
    op <= 2'h0;
    wdt_pulse;
    wt(3, 1'b1);
    wt(0, 1'b1);
    // Every cause has been raised once by now; status survives resets
    rdchk(OFS_STATUS, (32'(ST_RUN) << STATE_LSB) | 32'h7f);
    bus(1'b1, OFS_STATUS, 32'h7f);
    rdchk(OFS_STATUS, 32'(ST_RUN) << STATE_LSB);
    $display("stop recovery test done");
    give_verdict;
  end
endmodule

bind rhpc_top rhpc_checker u_rhpc_checker (.clk_i, .rst_n_i, .por_i, .supply_brownout_reset_i,
  .watchdog_timer_timeout_i, .watchdog_reset_select_option_i, .ext_reset_n_i,
  .reset_pin_alt_en_i, .halt_instr_i, .stop_instr_i, .irq_i, .sys_reset_n_o, .stop_recovery_o,
  .cpu_run_o, .halt_mode_o, .stop_mode_o, .osc_en_o, .sys_clk_en_o, .wdt_osc_en_o);
